// [rtl/egmc_pkg.sv]
// Package: register map, field positions, frame timing and carriers
package egmc_pkg;
	localparam int GROUPS = 4;
	localparam logic [11:0] ADDR_GROUP0 = 12'h0400;
	localparam logic [11:0] ADDR_GROUP1 = 12'h0401;
	localparam logic [11:0] ADDR_GROUP2 = 12'h0402;
	localparam logic [11:0] ADDR_GROUP3 = 12'h0403;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam int BIT_POWER_ON = 0;
	localparam int BIT_LAW = 1;
	localparam int BIT_FORMAT = 2;
	localparam int BIT_MASK_A = 3;
	localparam int BIT_MASK_B = 4;
	localparam int BIT_GLOBAL_MASK = 5;
	localparam logic [7:0] GROUP_WRITE_MASK = 8'h1F;
	localparam logic [7:0] GROUP0_WRITE_MASK = 8'h3F;
	// Frame is 125 us at 10 MHz
	localparam int FRAME_US = 125;
	localparam int CLK_MHZ = 10;
	localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
	localparam int INIT_FRAMES = 2;
	localparam int BYPASS_FRAMES = 2;

	typedef struct packed {
		logic power_on;
		logic a_law;
		logic g711;
		logic initializing;
		logic init_start;
	} egmc_group_ctl_t;

	typedef struct packed {
		logic [7:0] rx;
		logic [7:0] tx;
	} egmc_pcm_t;
endpackage

// [rtl/egmc_bypass.sv]
// Two-frame PCM delay line used while a group is powered down
`timescale 1ns/1ps
module egmc_bypass #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Frame strobe and data
	input wire logic frame_i,
	input wire egmc_pkg::egmc_pcm_t in_i,
	output egmc_pkg::egmc_pcm_t out_o
);
	egmc_pkg::egmc_pcm_t stage [DEPTH];
	egmc_pkg::egmc_pcm_t next_stage [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_stage[i] = stage[i];
		end
		if (frame_i) begin
			next_stage[0] = in_i;
			for (int i = 1; i < DEPTH; i++) begin
				next_stage[i] = stage[i-1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (!nrst_i) begin
				stage[i] <= '0;
			end else begin
				stage[i] <= next_stage[i];
			end
		end
	end

	assign out_o = stage[DEPTH-1];
endmodule

// [rtl/egmc_top.sv]
// Echo group main control registers, detector interrupt gating, bypass
`timescale 1ns/1ps
// How it works
// (R01) Global mask set blocks all detector interrupts; cleared lets per-detector masks decide while bit 0 powers the group.
// (R02) Global mask bit exists only in the group 0 register.
// (R03) Masks block reporting only; detectors keep detecting.
// (R04) Bit 4 set suppresses canceller B detector interrupt of the group.
// (R05) Bit 3 set suppresses canceller A detector interrupt of the group.
// (R06) Bit 2 set selects G.711 coding; cleared selects sign-magnitude.
// (R07) Bit 1 set selects A-law; cleared selects mu-law.
// (R08) Bit 0 set powers the group; cleared powers it down.
// (R09) Powered-down group passes PCM receive and send with two frames delay.
// (R10) Rising power bit starts initialization of both cancellers.
// (R11) Host waits two frames after power-up before channel writes.
// (R12) Groups 1..3 registers at 401..403, reset zero, bits 7..5 unused.
// (R13) Interrupt raised only when global and detector masks are both clear.
module egmc_top #(
	parameter int FRAME_CYCLES = egmc_pkg::FRAME_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Tone detector events, two per group (bit 2g = A, 2g+1 = B)
	input wire logic [2*egmc_pkg::GROUPS-1:0] det_event_i,
	output logic [2*egmc_pkg::GROUPS-1:0] det_irq_o,
	// Per-group canceller controls
	output egmc_pkg::egmc_group_ctl_t [egmc_pkg::GROUPS-1:0] group_ctl_o,
	// Frame strobe out
	output logic frame_o,
	// PCM paths per group: from cancellers and from port
	input wire egmc_pkg::egmc_pcm_t [egmc_pkg::GROUPS-1:0] pcm_in_i,
	input wire egmc_pkg::egmc_pcm_t [egmc_pkg::GROUPS-1:0] ec_out_i,
	output egmc_pkg::egmc_pcm_t [egmc_pkg::GROUPS-1:0] pcm_out_o
);
	localparam int G = egmc_pkg::GROUPS;
	localparam int FCW = $clog2(FRAME_CYCLES + 1);
	localparam logic [FCW-1:0] FRAME_LAST = FCW'(FRAME_CYCLES - 1);

	logic [7:0] ctl [G];
	logic [7:0] next_ctl [G];
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [FCW-1:0] frame_cnt;
	logic [FCW-1:0] next_frame_cnt;
	logic frame_tick;
	logic [G-1:0] power_q;
	logic [G-1:0] next_power_q;
	logic [1:0] init_cnt [G];
	logic [1:0] next_init_cnt [G];
	logic [2*G-1:0] irq;
	logic [2*G-1:0] next_irq;
	logic [2*G-1:0] det_meta;
	logic [2*G-1:0] det_sync;
	egmc_pkg::egmc_pcm_t [G-1:0] pcm_out;
	egmc_pkg::egmc_pcm_t [G-1:0] next_pcm_out;
	egmc_pkg::egmc_pcm_t bypass_out [G];

	// Frame divider
	always_comb begin
		frame_tick = (frame_cnt == FRAME_LAST);
		next_frame_cnt = frame_tick ? '0 : frame_cnt + FCW'(1);
	end

	// Register file
	always_comb begin
		for (int g = 0; g < G; g++) begin
			next_ctl[g] = ctl[g];
		end
		next_rdata = 8'h00;
		if (wr_i) begin
			if (addr_i == egmc_pkg::ADDR_GROUP0) begin
				// (R02) Global mask group 0 only
				next_ctl[0] = wdata_i & egmc_pkg::GROUP0_WRITE_MASK;
			// (R12) Group registers 401..403
			end else if (addr_i == egmc_pkg::ADDR_GROUP1) begin
				next_ctl[1] = wdata_i & egmc_pkg::GROUP_WRITE_MASK;
			end else if (addr_i == egmc_pkg::ADDR_GROUP2) begin
				next_ctl[2] = wdata_i & egmc_pkg::GROUP_WRITE_MASK;
			end else if (addr_i == egmc_pkg::ADDR_GROUP3) begin
				next_ctl[3] = wdata_i & egmc_pkg::GROUP_WRITE_MASK;
			end
		end
		if (rd_i) begin
			if (addr_i == egmc_pkg::ADDR_GROUP0) begin
				next_rdata = ctl[0];
			end else if (addr_i == egmc_pkg::ADDR_GROUP1) begin
				next_rdata = ctl[1];
			end else if (addr_i == egmc_pkg::ADDR_GROUP2) begin
				next_rdata = ctl[2];
			end else if (addr_i == egmc_pkg::ADDR_GROUP3) begin
				next_rdata = ctl[3];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			for (int g = 0; g < G; g++) begin
				ctl[g] <= egmc_pkg::RESET_VALUE;
			end
			rdata <= 8'h00;
			frame_cnt <= '0;
		end else begin
			for (int g = 0; g < G; g++) begin
				ctl[g] <= next_ctl[g];
			end
			rdata <= next_rdata;
			frame_cnt <= next_frame_cnt;
		end
	end

	// Detector events cross in from the cancellers' domain
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			det_meta <= '0;
			det_sync <= '0;
		end else begin
			det_meta <= det_event_i;
			det_sync <= det_meta;
		end
	end

	// Per-group control, init timer, interrupt gating, PCM select
	always_comb begin
		logic gmask;
		gmask = ctl[0][egmc_pkg::BIT_GLOBAL_MASK];
		for (int g = 0; g < G; g++) begin
			next_power_q[g] = ctl[g][egmc_pkg::BIT_POWER_ON];
			next_init_cnt[g] = init_cnt[g];
			// (R10) Rising power bit starts init
			if (ctl[g][egmc_pkg::BIT_POWER_ON] && !power_q[g]) begin
				next_init_cnt[g] = 2'(egmc_pkg::INIT_FRAMES);
			end else if (!ctl[g][egmc_pkg::BIT_POWER_ON]) begin
				next_init_cnt[g] = 2'd0;
			end else if (frame_tick && init_cnt[g] != 2'd0) begin
				next_init_cnt[g] = init_cnt[g] - 2'd1;
			end
			// (R01) Global mask gates all
			// (R13) Both masks must be clear
			// (R04) Canceller B mask
			// (R03) Detection itself untouched
			next_irq[2*g+1] = det_sync[2*g+1] && !gmask
				&& !ctl[g][egmc_pkg::BIT_MASK_B] && ctl[g][egmc_pkg::BIT_POWER_ON];
			// (R05) Canceller A mask
			next_irq[2*g] = det_sync[2*g] && !gmask
				&& !ctl[g][egmc_pkg::BIT_MASK_A] && ctl[g][egmc_pkg::BIT_POWER_ON];
			// (R09) Bypass when powered down
			next_pcm_out[g] = ctl[g][egmc_pkg::BIT_POWER_ON] ? ec_out_i[g] : bypass_out[g];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			power_q <= '0;
			irq <= '0;
			pcm_out <= '0;
			for (int g = 0; g < G; g++) begin
				init_cnt[g] <= 2'd0;
			end
		end else begin
			power_q <= next_power_q;
			irq <= next_irq;
			pcm_out <= next_pcm_out;
			for (int g = 0; g < G; g++) begin
				init_cnt[g] <= next_init_cnt[g];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < G; gi++) begin : g_group
			egmc_bypass #(
				.DEPTH(egmc_pkg::BYPASS_FRAMES)
			) u_bypass (
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.frame_i(frame_tick),
				.in_i(pcm_in_i[gi]),
				.out_o(bypass_out[gi])
			);
			// (R08) Power control out
			assign group_ctl_o[gi].power_on = ctl[gi][egmc_pkg::BIT_POWER_ON];
			// (R07) Law select
			assign group_ctl_o[gi].a_law = ctl[gi][egmc_pkg::BIT_LAW];
			// (R06) Format select
			assign group_ctl_o[gi].g711 = ctl[gi][egmc_pkg::BIT_FORMAT];
			// (R11) Busy until the second frame tick after start
			assign group_ctl_o[gi].initializing = (init_cnt[gi] != 2'd0);
			assign group_ctl_o[gi].init_start = ctl[gi][egmc_pkg::BIT_POWER_ON] && !power_q[gi];
		end
	endgenerate

	assign rdata_o = rdata;
	assign det_irq_o = irq;
	assign pcm_out_o = pcm_out;
	assign frame_o = frame_tick;
endmodule

// [sim/egmc_asserts.sv]
// Checker for the group main control block
`timescale 1ns/1ps
module egmc_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	// Outputs, and the canceller PCM input
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] det_irq_o,
	input wire egmc_pkg::egmc_group_ctl_t [3:0] group_ctl_o,
	input wire egmc_pkg::egmc_pcm_t [3:0] ec_out_i,
	input wire egmc_pkg::egmc_pcm_t [3:0] pcm_out_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Mask bit written, then three quiet cycles
	sequence s_wr(a, b);
		wr_i && addr_i == a && wdata_i[b] ##1 (!wr_i)[*3];
	endsequence
	property p_pwr;
		wr_i && addr_i == 12'h0401 |=> group_ctl_o[1].power_on == $past(wdata_i[0]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit");
	property p_law;
		wr_i && addr_i == 12'h0402 |=> group_ctl_o[2].a_law == $past(wdata_i[1]);
	endproperty
	a_law: assert property (p_law) else $error("law bit");
	property p_fmt;
		wr_i && addr_i == 12'h0403 |=> group_ctl_o[3].g711 == $past(wdata_i[2]);
	endproperty
	a_fmt: assert property (p_fmt) else $error("format bit");
	// Start pulse, then busy flag
	sequence s_init_run;
		group_ctl_o[1].init_start
			##1 (!group_ctl_o[1].init_start && group_ctl_o[1].initializing);
	endsequence
	property p_init;
		$rose(group_ctl_o[1].power_on) |-> s_init_run;
	endproperty
	a_init: assert property (p_init) else $error("no init");
	property p_rdz;
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data not idle");
	property p_glob;
		s_wr(12'h0400, 5) |-> det_irq_o == 8'h00;
	endproperty
	a_glob: assert property (p_glob) else $error("global mask");
	property p_mb;
		s_wr(12'h0401, 4) |-> !det_irq_o[3];
	endproperty
	a_mb: assert property (p_mb) else $error("mask b");
	property p_ma;
		s_wr(12'h0401, 3) |-> !det_irq_o[2];
	endproperty
	a_ma: assert property (p_ma) else $error("mask a");
	property p_live;
		group_ctl_o[1].power_on |=> pcm_out_o[1] == $past(ec_out_i[1]);
	endproperty
	a_live: assert property (p_live) else $error("pcm path");
endmodule
bind egmc_top egmc_asserts egmc_asserts_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.det_irq_o(det_irq_o), .group_ctl_o(group_ctl_o),
	.ec_out_i(ec_out_i), .pcm_out_o(pcm_out_o));

// [sim/tb.sv]
// Self-checking bench for the group main control block
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [11:0] addr_i = 12'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] det_event_i = 8'h00;
	egmc_pkg::egmc_pcm_t [3:0] pcm_in_i = '0;
	egmc_pkg::egmc_pcm_t [3:0] ec_out_i = {4{16'h3c3c}};
	logic [7:0] rdata_o;
	logic [7:0] det_irq_o;
	egmc_pkg::egmc_group_ctl_t [3:0] group_ctl_o;
	logic frame_o;
	egmc_pkg::egmc_pcm_t [3:0] pcm_out_o;
	int err_total = 0;
	int check_count = 0;
	egmc_top #(.FRAME_CYCLES(8)) egmc_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.det_event_i(det_event_i), .det_irq_o(det_irq_o), .group_ctl_o(group_ctl_o),
		.frame_o(frame_o), .pcm_in_i(pcm_in_i), .ec_out_i(ec_out_i), .pcm_out_o(pcm_out_o));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		ck({8'h00, rdata_o}, {8'h00, e});
		@(posedge clk_i);
		#1;
		ck({8'h00, rdata_o}, 16'h0000);
	endtask
	task automatic irq(input logic [7:0] e);
		repeat (4) @(posedge clk_i);
		#1;
		ck({8'h00, det_irq_o}, {8'h00, e});
	endtask
	// Bounded wait for a frame tick
	task automatic wf;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (frame_o !== 1'b1 && n < 20);
		if (frame_o !== 1'b1) begin
			err_total++;
			results;
		end
	endtask
	task automatic regs;
		for (int g = 0; g < 4; g++) begin
			rd(12'h0400 + 12'(g), 8'h00);
			wr(12'h0400 + 12'(g), 8'hff);
			rd(12'h0400 + 12'(g), g == 0 ? 8'h3f : 8'h1f);
			wr(12'h0400 + 12'(g), 8'h00);
		end
		wr(12'h0404, 8'hff);
		rd(12'h0404, 8'h00);
		$display("register test done");
	endtask
	task automatic masks;
		logic [7:0] m [4] = '{8'h01, 8'h11, 8'h09, 8'h19};
		logic [7:0] e [4] = '{8'h0f, 8'h07, 8'h0b, 8'h03};
		wr(12'h0400, 8'h01);
		det_event_i <= 8'h0f;
		for (int i = 0; i < 4; i++) begin
			wr(12'h0401, m[i]);
			irq(e[i]);
		end
		wr(12'h0400, 8'h21);
		irq(8'h00);
		wr(12'h0400, 8'h01);
		irq(8'h03);
		wr(12'h0401, 8'h00);
		$display("interrupt test done");
	endtask
	task automatic ctlout;
		wr(12'h0402, 8'h07);
		#1;
		ck({11'h000, group_ctl_o[2]}, 16'h001d);
		@(posedge clk_i);
		#1;
		ck({11'h000, group_ctl_o[2]}, 16'h001e);
		wf;
		ck({11'h000, group_ctl_o[2]}, 16'h001e);
		wf;
		@(posedge clk_i);
		#1;
		ck({11'h000, group_ctl_o[2]}, 16'h001c);
		wr(12'h0402, 8'h00);
		#1;
		ck({11'h000, group_ctl_o[2]}, 16'h0000);
		wr(12'h0403, 8'h02);
		#1;
		ck({11'h000, group_ctl_o[3]}, 16'h0008);
		wr(12'h0403, 8'h04);
		#1;
		ck({11'h000, group_ctl_o[3]}, 16'h0004);
		wr(12'h0403, 8'h00);
		$display("control output test done");
	endtask
	task automatic bypass;
		ec_out_i[0] <= 16'h1234;
		wf;
		@(posedge clk_i);
		pcm_in_i[1] <= 16'ha55a;
		#1;
		ck(pcm_out_o[0], 16'h1234);
		wf;
		wf;
		ck(pcm_out_o[1], 16'h0000);
		@(posedge clk_i);
		#1;
		ck(pcm_out_o[1], 16'h0000);
		@(posedge clk_i);
		#1;
		ck(pcm_out_o[1], 16'ha55a);
		$display("bypass test done");
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		regs;
		masks;
		ctlout;
		bypass;
		results;
	end
endmodule
